// >>> rps_pin_select.sv
// Purpose: remappable pin select with lock, key sequence and shadow check
// Assumes: one clock pclk, APB slave, peripherals on the same clock
// Notes:   remap outputs are registered, so routing adds one cycle

`timescale 1ns/1ps

module rps_pin_select #(
    parameter int unsigned NPINS = 26
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     ce,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     one_way_lock_cfg,
    input  wire logic [NPINS-1:0]         pin_in,
    input  wire logic [NPINS-1:0]         pin_analog,
    input  rps_pkg::rps_periph_out_t      periph_out,
    output rps_pkg::rps_periph_in_t       periph_in,
    output logic      [NPINS-1:0]         pin_out,
    output logic      [NPINS-1:0]         pin_remap_oe,
    output logic                          cfg_mismatch_rst
);

    // ==========================================================
    // Elaboration check
    if (NPINS < 1 || NPINS > rps_pkg::MAX_PINS) begin : g_bad_npins
        $error("rps_pin_select: NPINS must be 1 to 26");
    end

    // Carrier width must equal the selector count, or routing would shift
    if ($bits(rps_pkg::rps_periph_in_t) != rps_pkg::NUM_IN) begin : g_bad_in
        $error("rps_pin_select: input carrier width");
    end

    // ==========================================================
    // State
    typedef struct packed {
        logic [rps_pkg::NUM_IN-1:0][4:0] in_sel;
        logic [NPINS-1:0][4:0]           out_sel;
        logic [rps_pkg::NUM_IN-1:0][4:0] sh_in;
        logic [NPINS-1:0][4:0]           sh_out;
        logic                            lock;
        logic                            set_once;
        rps_pkg::rps_seq_t               seq;
        logic [1:0]                      ow_sync;
        logic [NPINS-1:0]                pin_m;
        logic [NPINS-1:0]                pin_s;
        logic                            pready;
        logic                            pslverr;
        logic [31:0]                     prdata;
        logic [rps_pkg::NUM_IN-1:0]      route;
        logic [NPINS-1:0]                pout;
        logic [NPINS-1:0]                poe;
        logic                            mismatch;
    } rps_state_t;

    rps_state_t st_r;
    rps_state_t st_nxt;

    // ==========================================================
    // Functions
    function automatic logic is_in_addr(input logic [11:0] a);
        return (a >= rps_pkg::IN_SEL_BASE) && (a[1:0] == 2'h0) &&
               (a < 12'(rps_pkg::IN_SEL_BASE + 4 * rps_pkg::NUM_IN));
    endfunction

    function automatic logic is_out_addr(input logic [11:0] a);
        return (a >= rps_pkg::OUT_SEL_BASE) && (a[1:0] == 2'h0) &&
               (a < 12'(rps_pkg::OUT_SEL_BASE + 4 * NPINS));
    endfunction

    function automatic logic [9:0] word_index(input logic [11:0] a, input logic [11:0] base);
        logic [11:0] d;
        d = a - base;
        return d[11:2];
    endfunction

    // Code 31 grounds the input; codes past the last pin read low too
    function automatic logic pick_pin(input logic [4:0] sel, input logic [NPINS-1:0] pins);
        logic r;
        r = 1'b0;
        if (sel != rps_pkg::IN_TIE_GND && 32'(sel) < NPINS) begin
            r = pins[sel];
        end
        return r;
    endfunction

    function automatic logic [31:0] out_vector(input rps_pkg::rps_periph_out_t p);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[rps_pkg::OUT_COMP_A]       = p.comparator_a_out;
        v[rps_pkg::OUT_COMP_B]       = p.comparator_b_out;
        v[rps_pkg::OUT_SERIAL1_TX]   = p.serial1_tx;
        v[rps_pkg::OUT_SERIAL1_RTS]  = p.serial1_rts_out;
        v[rps_pkg::OUT_SERIAL2_TX]   = p.serial2_tx;
        v[rps_pkg::OUT_SERIAL2_RTS]  = p.serial2_rts_out;
        v[rps_pkg::OUT_SPI_A_DATA]   = p.spi_a_data_out;
        v[rps_pkg::OUT_SPI_A_CLK]    = p.spi_a_clk_out;
        v[rps_pkg::OUT_SPI_A_SELECT] = p.spi_a_select_out;
        v[rps_pkg::OUT_SPI_B_DATA]   = p.spi_b_data_out;
        v[rps_pkg::OUT_SPI_B_CLK]    = p.spi_b_clk_out;
        v[rps_pkg::OUT_SPI_B_SELECT] = p.spi_b_select_out;
        v[rps_pkg::OUT_CAN_TX]       = p.can_tx_out;
        v[rps_pkg::OUT_COMPARE_CH1]  = p.compare_ch1_out;
        v[rps_pkg::OUT_COMPARE_CH2]  = p.compare_ch2_out;
        v[rps_pkg::OUT_COMPARE_CH3]  = p.compare_ch3_out;
        v[rps_pkg::OUT_COMPARE_CH4]  = p.compare_ch4_out;
        return v;
    endfunction

    // Unassigned codes behave like the null code
    function automatic logic code_assigned(input logic [4:0] c);
        logic ok;
        unique case (c)
            rps_pkg::OUT_COMP_A, rps_pkg::OUT_COMP_B,
            rps_pkg::OUT_SERIAL1_TX, rps_pkg::OUT_SERIAL1_RTS,
            rps_pkg::OUT_SERIAL2_TX, rps_pkg::OUT_SERIAL2_RTS,
            rps_pkg::OUT_SPI_A_DATA, rps_pkg::OUT_SPI_A_CLK,
            rps_pkg::OUT_SPI_A_SELECT, rps_pkg::OUT_SPI_B_DATA,
            rps_pkg::OUT_SPI_B_CLK, rps_pkg::OUT_SPI_B_SELECT,
            rps_pkg::OUT_CAN_TX, rps_pkg::OUT_COMPARE_CH1,
            rps_pkg::OUT_COMPARE_CH2, rps_pkg::OUT_COMPARE_CH3,
            rps_pkg::OUT_COMPARE_CH4: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // ==========================================================
    // Next state
    logic        acc;
    logic        wr;
    logic        hit_in;
    logic        hit_out;
    logic        hit_osc;
    logic [9:0]  idx_in;
    logic [9:0]  idx_out;
    logic [31:0] rd;
    logic [31:0] ovec;

    always_comb begin
        st_nxt  = st_r;
        acc     = psel & penable;
        hit_in  = is_in_addr(paddr);
        hit_out = is_out_addr(paddr);
        hit_osc = (paddr == rps_pkg::OSC_CTRL_ADDR);
        idx_in  = word_index(paddr, rps_pkg::IN_SEL_BASE);
        idx_out = word_index(paddr, rps_pkg::OUT_SEL_BASE);
        wr      = acc & st_r.pready & pwrite & (hit_in | hit_out | hit_osc);
        ovec    = out_vector(periph_out);

        // Pins come from outside the clock domain
        st_nxt.pin_m   = pin_in;
        st_nxt.pin_s   = st_r.pin_m;
        st_nxt.ow_sync = {st_r.ow_sync[0], one_way_lock_cfg};

        // One wait state: pready rises in the second access cycle
        // Reads leave the key sequence alone
        rd = 32'h0000_0000;
        if (hit_in) begin
            rd[4:0] = st_r.in_sel[idx_in[4:0]];
        end else if (hit_out) begin
            rd[4:0] = st_r.out_sel[idx_out[4:0]];
        end else if (hit_osc) begin
            rd[rps_pkg::LOCK_BIT]              = st_r.lock;
            rd[rps_pkg::ONE_WAY_BIT]           = st_r.ow_sync[1];
            rd[rps_pkg::MISMATCH_BIT]          = st_r.mismatch;
            rd[rps_pkg::SEQ_LSB+1:rps_pkg::SEQ_LSB] = st_r.seq;
        end
        st_nxt.pready  = acc & ~st_r.pready;
        st_nxt.pslverr = acc & ~st_r.pready & ~(hit_in | hit_out | hit_osc);
        if (acc & ~st_r.pready & ~pwrite) begin
            st_nxt.prdata = rd;
        end

        if (wr) begin
            if (hit_osc) begin
                unique case (st_r.seq)
                    rps_pkg::RPS_SEQ_KEY2: begin
                        // A one-way lock refuses to be cleared once set
                        if (!(st_r.ow_sync[1] && st_r.set_once)) begin
                            st_nxt.lock = pwdata[rps_pkg::LOCK_BIT];
                        end
                        if (pwdata[rps_pkg::LOCK_BIT]) begin
                            st_nxt.set_once = 1'b1;
                        end
                        st_nxt.seq = rps_pkg::RPS_SEQ_IDLE;
                    end
                    rps_pkg::RPS_SEQ_KEY1: begin
                        if (pwdata[7:0] == rps_pkg::UNLOCK_KEY2) begin
                            st_nxt.seq = rps_pkg::RPS_SEQ_KEY2;
                        end else if (pwdata[7:0] == rps_pkg::UNLOCK_KEY1) begin
                            st_nxt.seq = rps_pkg::RPS_SEQ_KEY1;
                        end else begin
                            st_nxt.seq = rps_pkg::RPS_SEQ_IDLE;
                        end
                    end
                    default: begin
                        if (pwdata[7:0] == rps_pkg::UNLOCK_KEY1) begin
                            st_nxt.seq = rps_pkg::RPS_SEQ_KEY1;
                        end else begin
                            st_nxt.seq = rps_pkg::RPS_SEQ_IDLE;
                        end
                    end
                endcase
            end else begin
                st_nxt.seq = rps_pkg::RPS_SEQ_IDLE;
                // Locked writes are acknowledged without error and dropped
                if (!st_r.lock && hit_in) begin
                    st_nxt.in_sel[idx_in[4:0]] = pwdata[4:0];
                    st_nxt.sh_in[idx_in[4:0]]  = pwdata[4:0];
                end
                if (!st_r.lock && hit_out) begin
                    st_nxt.out_sel[idx_out[4:0]] = pwdata[4:0];
                    st_nxt.sh_out[idx_out[4:0]]  = pwdata[4:0];
                end
            end
        end

        // Shadow check; sticky until device reset
        if (st_r.in_sel != st_r.sh_in || st_r.out_sel != st_r.sh_out) begin
            st_nxt.mismatch = 1'b1;
        end

        // Input routing
        for (int i = 0; i < rps_pkg::NUM_IN; i++) begin
            st_nxt.route[i] = pick_pin(st_r.in_sel[i], st_r.pin_s);
        end

        // Output routing; analog pins are never taken over
        for (int n = 0; n < NPINS; n++) begin
            st_nxt.pout[n] = ovec[st_r.out_sel[n]];
            st_nxt.poe[n]  = code_assigned(st_r.out_sel[n]) & ~pin_analog[n];
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r          <= '0;
            st_r.lock     <= rps_pkg::LOCK_RESET;
            st_r.seq      <= rps_pkg::RPS_SEQ_IDLE;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign prdata           = st_r.prdata;
    assign pready           = st_r.pready;
    assign pslverr          = st_r.pslverr;
    assign periph_in        = rps_pkg::rps_periph_in_t'(st_r.route);
    assign pin_out          = st_r.pout;
    assign pin_remap_oe     = st_r.poe;
    assign cfg_mismatch_rst = st_r.mismatch;

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);

    logic sel_wr;
    assign sel_wr = psel & penable & pready & pwrite &
                    (is_in_addr(paddr) | is_out_addr(paddr));

    // Writes to the oscillator control register
    logic osc_wr;
    assign osc_wr = psel & penable & pready & pwrite & (paddr == rps_pkg::OSC_CTRL_ADDR);

    locked_write_a: assert property (sel_wr && st_r.lock |-> !pslverr ##1
        $stable(st_r.in_sel) && $stable(st_r.out_sel))
        else $error("selector changed while locked");

    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");

    seq_legal_a: assert property (st_r.seq != 2'b11)
        else $error("illegal key state");

    first_key_a: assert property (st_r.seq == rps_pkg::RPS_SEQ_IDLE && osc_wr &&
        pwdata[7:0] == rps_pkg::UNLOCK_KEY1 |=> st_r.seq == rps_pkg::RPS_SEQ_KEY1)
        else $error("first key not taken");

    second_key_a: assert property (st_r.seq == rps_pkg::RPS_SEQ_KEY1 && osc_wr &&
        pwdata[7:0] == rps_pkg::UNLOCK_KEY2 |=> st_r.seq == rps_pkg::RPS_SEQ_KEY2)
        else $error("second key not taken");

    sel_abort_a: assert property (st_r.seq != rps_pkg::RPS_SEQ_IDLE && sel_wr |=>
        st_r.seq == rps_pkg::RPS_SEQ_IDLE)
        else $error("selector write kept keys");

    lock_write_a: assert property (osc_wr && st_r.seq == rps_pkg::RPS_SEQ_KEY2 &&
        !(st_r.ow_sync[1] && st_r.set_once) |=> st_r.lock == $past(pwdata[6]))
        else $error("lock op not applied");

    spare_code_a: assert property (st_r.out_sel[3] == 5'h0D |=> !pin_remap_oe[3])
        else $error("unassigned code drove a pin");

    analog_all_a: assert property (1'b1 |=>
        (pin_remap_oe & $past(pin_analog)) == '0)
        else $error("remap beat an analog pin");

    route_in_a: assert property (st_r.in_sel[11] == 5'h05 |=>
        periph_in.serial1_rx == $past(st_r.pin_s[5]))
        else $error("serial rx not routed");

    pin0_in_a: assert property (st_r.in_sel[1] == 5'h00 |=>
        periph_in.ext_irq_two == $past(st_r.pin_s[0]))
        else $error("code zero not pin zero");

    rd_hold_a: assert property (!(psel && penable && !pready && !pwrite) |=> $stable(prdata))
        else $error("read data moved");

    key_gate_a: assert property ($changed(st_r.lock) |->
        $past(st_r.seq) == rps_pkg::RPS_SEQ_KEY2)
        else $error("lock changed without key sequence");

    one_way_a: assert property (st_r.lock && st_r.set_once && st_r.ow_sync[1] |=>
        st_r.lock)
        else $error("one-way lock was cleared");

    lock_hold_a: assert property (!(psel && penable && pready && pwrite) |=>
        $stable(st_r.lock))
        else $error("lock changed without a write");

    null_out_a: assert property (st_r.out_sel[3] == rps_pkg::OUT_NULL |=>
        !pin_remap_oe[3])
        else $error("null code drove a pin");

    tie_gnd_a: assert property (st_r.in_sel[0] == rps_pkg::IN_TIE_GND |=>
        !periph_in.ext_irq_one)
        else $error("grounded input not low");

    out_map_a: assert property (st_r.out_sel[3] == rps_pkg::OUT_SERIAL1_TX &&
        !pin_analog[3] |=> pin_remap_oe[3] && pin_out[3] == $past(periph_out.serial1_tx))
        else $error("serial tx not routed");

    analog_pri_a: assert property (pin_analog[3] |=> !pin_remap_oe[3])
        else $error("remap overrode analog pin");

    key_abort_a: assert property (st_r.seq == rps_pkg::RPS_SEQ_KEY1 && psel &&
        penable && pready && pwrite && paddr == rps_pkg::OSC_CTRL_ADDR &&
        pwdata[7:0] != rps_pkg::UNLOCK_KEY2 && pwdata[7:0] != rps_pkg::UNLOCK_KEY1
        |=> st_r.seq == rps_pkg::RPS_SEQ_IDLE)
        else $error("bad key did not abort");

    shadow_a: assert property (st_r.in_sel != st_r.sh_in |=> cfg_mismatch_rst)
        else $error("mismatch not flagged");

    ready_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("pready timing wrong");

    unlock_c: cover property (st_r.seq == rps_pkg::RPS_SEQ_KEY2 ##1 !st_r.lock);
    relock_c: cover property (!st_r.lock ##[1:200] st_r.lock);
    route_c:  cover property (pin_remap_oe[0] && pin_remap_oe[1]);
    drop_c:   cover property (sel_wr && st_r.lock);
    abort_c:  cover property (st_r.seq == rps_pkg::RPS_SEQ_KEY1 ##1
        st_r.seq == rps_pkg::RPS_SEQ_IDLE);

endmodule

// >>> rps_pkg.sv
// Purpose: constants and carriers for the remappable pin select block
// Assumes: APB slave with 32-bit data, 12-bit byte address
// Notes:   one aligned word per selector, narrow fields in the low bits
//
// Behaviour
// - Every remappable peripheral input has its own 5-bit pin selector.
// - Every remappable pin has its own 5-bit output selector.
// - Output code zero disconnects the pin; default port logic keeps it.
// - Codes 1-6: comparators a/b, serial1 tx/rts, serial2 tx/rts.
// - Codes 7-9 first SPI data/clock/select out; 10-12 the second SPI.
// - Code 16 CAN transmit, codes 18-21 compare channels 1-4, rest unassigned.
// - Selectors exist for irqs, timer clocks, captures, fault, serial, SPI, CAN.
// - Up to 26 remappable pins; the variant sets how many exist.
// - An active remapped output beats digital port functions, never analog.
// - No exclusion between selectors; any mapping combination is accepted.
// - Remappable outputs have no default pin until a selector assigns one; inputs start on pin 0.
// - Selector writes while locked complete cleanly but change nothing.
// - Lock bit sits at bit 6 of the oscillator control register.
// - Lock bit changes only after keys 0x46 then 0x57 in its low byte.
// - Lock bit holds its value until changed again; never self-clears.
// - Shadow copies are compared continuously; a mismatch requests device reset.
// - With one-way setting active, a lock once set cannot be cleared.
// - Unprogrammed one-way setting reads active; programmed allows many sessions.
// - All selectors reset to zero: inputs on pin 0, outputs disconnected.
// - Lock bit resets to unlocked.
// - Input code all ones ties the peripheral input to ground.

package rps_pkg;

    // ==========================================================
    // Sizes
    localparam int unsigned NUM_IN   = 22;
    localparam int unsigned MAX_PINS = 26;
    localparam int unsigned SEL_W    = 5;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [11:0] IN_SEL_BASE   = 12'h000;
    localparam logic [11:0] OUT_SEL_BASE  = 12'h080;
    localparam logic [11:0] OSC_CTRL_ADDR = 12'h100;

    // ==========================================================
    // Oscillator control register fields and keys
    localparam int unsigned LOCK_BIT     = 6;
    localparam int unsigned ONE_WAY_BIT  = 8;
    localparam int unsigned MISMATCH_BIT = 9;
    localparam int unsigned SEQ_LSB      = 10;
    localparam logic [7:0]  UNLOCK_KEY1  = 8'h46;
    localparam logic [7:0]  UNLOCK_KEY2  = 8'h57;
    localparam logic        LOCK_RESET   = 1'h0;

    // ==========================================================
    // Selector codes
    localparam logic [4:0] SEL_RESET        = 5'h00;
    localparam logic [4:0] IN_TIE_GND       = 5'h1F;
    localparam logic [4:0] OUT_NULL         = 5'h00;
    localparam logic [4:0] OUT_COMP_A       = 5'h01;
    localparam logic [4:0] OUT_COMP_B       = 5'h02;
    localparam logic [4:0] OUT_SERIAL1_TX   = 5'h03;
    localparam logic [4:0] OUT_SERIAL1_RTS  = 5'h04;
    localparam logic [4:0] OUT_SERIAL2_TX   = 5'h05;
    localparam logic [4:0] OUT_SERIAL2_RTS  = 5'h06;
    localparam logic [4:0] OUT_SPI_A_DATA   = 5'h07;
    localparam logic [4:0] OUT_SPI_A_CLK    = 5'h08;
    localparam logic [4:0] OUT_SPI_A_SELECT = 5'h09;
    localparam logic [4:0] OUT_SPI_B_DATA   = 5'h0A;
    localparam logic [4:0] OUT_SPI_B_CLK    = 5'h0B;
    localparam logic [4:0] OUT_SPI_B_SELECT = 5'h0C;
    localparam logic [4:0] OUT_CAN_TX       = 5'h10;
    localparam logic [4:0] OUT_COMPARE_CH1  = 5'h12;
    localparam logic [4:0] OUT_COMPARE_CH2  = 5'h13;
    localparam logic [4:0] OUT_COMPARE_CH3  = 5'h14;
    localparam logic [4:0] OUT_COMPARE_CH4  = 5'h15;

    // ==========================================================
    // Key sequence states
    typedef enum logic [1:0] {
        RPS_SEQ_IDLE = 2'b00,
        RPS_SEQ_KEY1 = 2'b01,
        RPS_SEQ_KEY2 = 2'b10
    } rps_seq_t;

    // ==========================================================
    // Peripheral inputs; the last field is bit 0 and selector index 0
    typedef struct packed {
        logic can_rx_in;
        logic spi_b_select_in;
        logic spi_b_clk_in;
        logic spi_b_data_in;
        logic spi_a_select_in;
        logic spi_a_clk_in;
        logic spi_a_data_in;
        logic serial2_cts_in;
        logic serial2_rx;
        logic serial1_cts_in;
        logic serial1_rx;
        logic compare_fault_a;
        logic capture_ch8_in;
        logic capture_ch7_in;
        logic capture_ch2_in;
        logic capture_ch1_in;
        logic timer5_ext_clk;
        logic timer4_ext_clk;
        logic timer3_ext_clk;
        logic timer2_ext_clk;
        logic ext_irq_two;
        logic ext_irq_one;
    } rps_periph_in_t;

    // Peripheral outputs offered to the pins
    typedef struct packed {
        logic comparator_a_out;
        logic comparator_b_out;
        logic serial1_tx;
        logic serial1_rts_out;
        logic serial2_tx;
        logic serial2_rts_out;
        logic spi_a_data_out;
        logic spi_a_clk_out;
        logic spi_a_select_out;
        logic spi_b_data_out;
        logic spi_b_clk_out;
        logic spi_b_select_out;
        logic can_tx_out;
        logic compare_ch1_out;
        logic compare_ch2_out;
        logic compare_ch3_out;
        logic compare_ch4_out;
    } rps_periph_out_t;

endpackage

// >>> rps_periph_model.sv
// Purpose: far-side model of the peripherals and remappable pins
// Assumes: peripherals on pclk, pins launched on pclk edges
// Notes:   slow adds one stage on the pin path to stretch the latency

`timescale 1ns/1ps

module rps_periph_model #(
    parameter int unsigned NPINS = 26
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                slow,
    input  wire logic [NPINS-1:0]    pin_lvl,
    input  rps_pkg::rps_periph_out_t drv,
    output logic      [NPINS-1:0]    pin_in,
    output rps_pkg::rps_periph_out_t periph_out
);
    // ==========================================================
    // Pin levels and peripheral outputs
    logic [NPINS-1:0] stage_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_r    <= '0;
            pin_in     <= '0;
            periph_out <= '0;
        end else begin
            stage_r    <= pin_lvl;
            pin_in     <= slow ? stage_r : pin_lvl;
            periph_out <= drv;
        end
    end
endmodule

// >>> tb.sv
// Purpose: self-checking bench for the remappable pin select block
// Assumes: one wait state APB, routing settles within a few cycles
// Notes:   a shadow fault cannot be injected, so only its quiet state is seen

`timescale 1ns/1ps

module tb;
    localparam logic [11:0] OSC = rps_pkg::OSC_CTRL_ADDR;
    localparam logic [11:0] INB = rps_pkg::IN_SEL_BASE;
    localparam logic [11:0] OUTB = rps_pkg::OUT_SEL_BASE;
    logic                     pclk, presetn, psel, penable, pwrite, one_way, slow;
    logic                     pready, pslverr, mm_rst, er;
    logic [11:0]              paddr;
    logic [31:0]              pwdata, prdata, rd;
    logic [25:0]              pin_lvl, pin_in, pin_analog, pin_out, pin_oe;
    rps_pkg::rps_periph_out_t pdrv, po;
    rps_pkg::rps_periph_in_t  pi;
    logic [4:0]               codes [18];
    int                       err_total, n_compared;

    rps_pin_select #(.NPINS(26)) uut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .one_way_lock_cfg(one_way),
        .pin_in(pin_in), .pin_analog(pin_analog), .periph_out(po), .periph_in(pi),
        .pin_out(pin_out), .pin_remap_oe(pin_oe), .cfg_mismatch_rst(mm_rst));
    rps_periph_model #(.NPINS(26)) far (.pclk(pclk), .presetn(presetn), .slow(slow),
        .pin_lvl(pin_lvl), .drv(pdrv), .pin_in(pin_in), .periph_out(po));

    // ==========================================================
    // Clock and shared tasks
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        idle(8);
        presetn <= 1'b1;
    endtask

    // Request held until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic keys(input logic [31:0] op);
        xfer(1, OSC, 32'h46);
        xfer(1, OSC, 32'h57);
        xfer(1, OSC, op);
    endtask

    function automatic int obit(input logic [4:0] c);
        return (c <= 12) ? 17 - c : ((c == 16) ? 4 : 21 - c);
    endfunction

    // ==========================================================
    // Tests
    initial begin
        {presetn, psel, penable, pwrite, one_way, slow} = '0;
        {paddr, pwdata, pin_lvl, pin_analog} = '0;
        pdrv = '0;
        codes = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
                  5'h0A, 5'h0B, 5'h0C, 5'h10, 5'h12, 5'h13, 5'h14, 5'h15, 5'h0D};
        do_reset();
        xfer(0, INB + 12'h02C, '0);
        chk(rd, '0);
        xfer(0, OUTB + 12'h00C, '0);
        chk(rd, '0);
        xfer(0, OSC, '0);
        chk(rd & 32'h340, '0);
        chk(pin_oe, '0);
        xfer(0, 12'h200, '0);
        chk(er, 1'b1);
        $display("test reset done");
        pin_lvl <= '1;
        xfer(1, INB + 12'h02C, 32'h5);
        xfer(1, INB + 12'h030, 32'h5);
        xfer(1, INB, 32'h1F);
        idle(6);
        chk({pi.serial1_rx, pi.serial1_cts_in, pi.ext_irq_one, pi.ext_irq_two}, 4'hD);
        slow <= 1'b1;
        pin_lvl <= ~26'h20;
        idle(7);
        chk({pi.serial1_rx, pi.serial1_cts_in, pi.ext_irq_one, pi.ext_irq_two}, 4'h1);
        $display("test input routing done");
        foreach (codes[i]) begin
            xfer(1, OUTB + 12'h00C, {27'h0, codes[i]});
            pdrv <= rps_pkg::rps_periph_out_t'(17'h1 << obit(codes[i]));
            idle(3);
            chk(pin_oe, (codes[i] == 5'h0D) ? 26'h0 : 26'h8);
            chk(pin_out[3], codes[i] != 5'h0D);
            pdrv <= '0;
            idle(3);
            chk(pin_out[3], 1'b0);
        end
        xfer(1, OUTB + 12'h00C, 32'h3);
        pin_analog <= 26'h8;
        idle(3);
        chk(pin_oe, '0);
        pin_analog <= '0;
        xfer(1, OUTB + 12'h00C, 32'h0);
        idle(3);
        chk(pin_oe, '0);
        $display("test output codes done");
        keys(32'h40);
        xfer(0, OSC, '0);
        chk(rd[6], 1'b1);
        xfer(1, INB + 12'h02C, 32'h7);
        chk(er, 1'b0);
        xfer(0, INB + 12'h02C, '0);
        chk(rd, 32'h5);
        xfer(1, OSC, 32'h46);
        xfer(1, INB, '0);
        xfer(1, OSC, 32'h57);
        xfer(1, OSC, 32'h46);
        xfer(1, OSC, 32'h12);
        xfer(1, OSC, 32'h0);
        xfer(0, OSC, '0);
        chk(rd[6], 1'b1);
        keys(32'h0);
        xfer(0, OSC, '0);
        chk(rd[6], 1'b0);
        xfer(1, INB + 12'h02C, 32'h7);
        xfer(1, OUTB + 12'h010, 32'h3);
        xfer(0, INB + 12'h02C, '0);
        chk(rd, 32'h7);
        xfer(0, OSC, '0);
        chk(rd[6], 1'b0);
        $display("test lock done");
        one_way <= 1'b1;
        do_reset();
        idle(3);
        keys(32'h40);
        keys(32'h0);
        xfer(0, OSC, '0);
        chk(rd & 32'h340, 32'h140);
        xfer(1, INB + 12'h02C, 32'h9);
        xfer(0, INB + 12'h02C, '0);
        chk(rd, '0);
        chk(mm_rst, 1'b0);
        $display("test one way done");
        print_verdict();
    end
endmodule
